//--- rtl/rcw_loader_pkg.sv
// constants and types shared by the reset configuration word loader
`default_nettype none
package rcw_loader_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONFIG_WORD_LO = 8'h00;
  localparam logic [7:0] OFS_CONFIG_WORD_HI = 8'h04;
  localparam logic [7:0] OFS_RESET_STATUS = 8'h08;
  localparam logic [7:0] OFS_PLL_MODE = 8'h0C;
  localparam logic [7:0] OFS_RESET_CONTROL = 8'h10;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // reset source strap codes
  localparam logic [2:0] SRC_LOCAL_BUS = 3'h0;
  localparam logic [2:0] SRC_RESERVED = 3'h1;
  localparam logic [2:0] SRC_I2C = 3'h2;
  localparam logic [2:0] SRC_FIXED_FIRST = 3'h3;
  // high word field positions
  localparam int HI_HOST_BIT = 31;
  localparam int HI_BOOT_SEQ_BIT = 30;
  localparam int HI_MULT_LSB = 24;
  localparam int MULT_W = 4;
  // reset status bit positions
  localparam int RS_FAIL_BIT = 0;
  localparam int RS_SRC_LSB = 1;
  localparam int RS_DIV_BIT = 4;
  localparam int RS_LATCHED_BIT = 5;
  localparam int RS_CORE_RUN_BIT = 6;
  // pll mode bit positions
  localparam int PM_BUS_HALF_BIT = 4;
  localparam int PM_CORE_DOUBLE_BIT = 5;
  localparam int PM_HOST_BIT = 6;
  // reset control bit positions
  localparam int RC_SOFT_BIT = 0;
  localparam int RC_HARD_BIT = 1;
  // flash fetch: eight bytes, stride of eight locations from address zero
  localparam int RCW_BYTES = 8;
  localparam logic [5:0] FLASH_BASE = 6'h00;
  localparam logic [5:0] FLASH_STRIDE = 6'h08;
  // i2c eeprom access
  localparam logic [6:0] EEPROM_DEV_ADDR = 7'h50;
  localparam logic [15:0] EEPROM_RCW_BASE = 16'h0000;
  localparam logic [15:0] EEPROM_BOOT_BASE = 16'h0008;
  localparam logic [23:0] BOOT_PREAMBLE = 24'hAA55AA;
  localparam logic [15:0] BOOT_END_ADDR = 16'hFFFF;
  localparam int BOOT_PRE_BYTES = 3;
  localparam int BOOT_REC_BYTES = 6;
  // built-in configuration word sets 0..4, {low, high}, values arbitrary
  localparam logic [4:0][63:0] FIXED_RCW_SETS = {
    64'h0000_0004_8400_0000,
    64'h0000_0003_8300_0000,
    64'h0000_0002_0400_0000,
    64'h0000_0001_8200_0000,
    64'h0000_0000_8400_0000
  };

  typedef enum logic [3:0] {
    ST_DISPATCH,
    ST_FLASH,
    ST_I2C,
    ST_FIXED,
    ST_LATCH,
    ST_FAIL,
    ST_WAIT_HARD,
    ST_BOOT_PRE,
    ST_BOOT_REC,
    ST_RUN
  } load_state_t;
endpackage
`default_nettype wire

//--- rtl/reset_config_word_loader.sv
// reset configuration word loader with axi4-lite status registers
// Functional notes
// R1 - strap 000 loads words from local bus
// R2 - board never presents reserved strap 001
// R3 - strap 010 loads word from i2c eeprom
// R4 - straps 011 to 111 pick fixed sets
// R5 - load mode from straps captured at power-on
// R6 - divide strap captured during power-on reset
// R7 - divide strap high: full-rate bus clocks
// R8 - divide strap low: halved bus, doubled core; code halves bus only in host mode, doubles core only outside it
// R9 - load runs on power-on and hard reset
// R10 - flash image starts at address zero
// R11 - eight bytes read at eight-location stride
// R12 - b0-b3 low word, top lane used
// R13 - eeprom uses two-byte memory addressing
// R14 - eeprom called at fixed slave address
// R15 - i2c held reset after latch until hard release
// R16 - high word bit enables boot sequencer
// R17 - i2c load failure sets fail flag
// R18 - preamble or crc errors stay silent
// R19 - hard and soft reset are open drain
// R20 - configuration and status registers read-only
// R21 - strap pins shared with general purpose lines
// R22 - blank flash gets no fallback words
// R23 - shared pins are inputs during power-on reset
// R24 - straps sampled only on running clock
// R25 - outputs inactive until both words latched
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
module reset_config_word_loader
  import rcw_loader_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic power_on_reset_n,
  input wire logic hard_reset_n_in,
  output logic hard_reset_n_out,
  output logic hard_reset_n_oe,
  input wire logic soft_reset_n_in,
  output logic soft_reset_n_out,
  output logic soft_reset_n_oe,
  input wire logic [2:0] local_bus_general_purpose_line_in,
  output logic [2:0] local_bus_general_purpose_line_out,
  output logic [2:0] local_bus_general_purpose_line_oe,
  input wire logic [2:0] lbc_general_purpose_line,
  input wire logic input_divide_strap,
  output logic flash_rd_req,
  output logic [5:0] flash_rd_addr,
  input wire logic flash_rd_ack,
  input wire logic [15:0] flash_rd_data,
  output logic i2c_rd_req,
  output logic [6:0] i2c_dev_addr,
  output logic [15:0] i2c_mem_addr,
  input wire logic i2c_rd_ack,
  input wire logic i2c_rd_err,
  input wire logic [7:0] i2c_rd_data,
  output logic i2c_hold_reset,
  output logic cfg_wr_valid,
  output logic [15:0] cfg_wr_addr,
  output logic [31:0] cfg_wr_data,
  output logic core_release,
  output logic config_valid,
  output logic [31:0] config_word_lo,
  output logic [31:0] config_word_hi,
  output logic [MULT_W-1:0] system_pll_multiplier,
  output logic bus_clk_half,
  output logic core_clk_double
);

  typedef struct packed {
    load_state_t st;
    logic [2:0] src;
    logic div;
    logic [3:0] idx;
    logic [63:0] shreg;
    logic [31:0] lo;
    logic [31:0] hi;
    logic latched;
    logic fail;
    logic hard_drive;
    logic flash_req;
    logic i2c_req;
    logic [15:0] addr;
    logic [47:0] rec;
    logic wr_valid;
    logic [15:0] wr_addr;
    logic [31:0] wr_data;
    logic [1:0] ctrl;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t q;
  state_t d;

  logic host_mode;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic [7:0] wr_addr_eff;
  logic [31:0] wr_data_eff;
  logic [31:0] status_word;
  logic [31:0] pll_word;

  assign host_mode = q.hi[HI_HOST_BIT];
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign wr_addr_eff = q.aw_got ? q.aw_addr : s_axi_awaddr;
  assign wr_data_eff = q.w_got ? q.w_data : s_axi_wdata;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[RS_FAIL_BIT] = q.fail;
    status_word[RS_SRC_LSB +: 3] = q.src;
    status_word[RS_DIV_BIT] = q.div;
    status_word[RS_LATCHED_BIT] = q.latched;
    status_word[RS_CORE_RUN_BIT] = (q.st == ST_RUN);
    pll_word = 32'h0000_0000;
    pll_word[MULT_W-1:0] = system_pll_multiplier;
    pll_word[PM_BUS_HALF_BIT] = bus_clk_half;
    pll_word[PM_CORE_DOUBLE_BIT] = core_clk_double;
    pll_word[PM_HOST_BIT] = q.latched && host_mode;
  end

  always_comb
  begin
    d = q;
    d.wr_valid = 1'b0;
    // loader sequence
    if (!power_on_reset_n)
    begin
      // straps follow the pins every clock while power-on reset is low
      d.src = local_bus_general_purpose_line_in; // R5 R21 R24
      d.div = input_divide_strap; // R6
      d.st = ST_DISPATCH;
      d.latched = 1'b0;
      d.fail = 1'b0;
      d.hard_drive = 1'b1;
      d.flash_req = 1'b0;
      d.i2c_req = 1'b0;
      d.idx = 4'h0;
      d.ctrl = 2'h0;
    end
    else
    begin
      case (q.st)
        ST_DISPATCH:
        begin
          d.idx = 4'h0;
          d.hard_drive = 1'b1;
          if (q.src == SRC_LOCAL_BUS || q.src == SRC_RESERVED)
          begin
            d.st = ST_FLASH; // R1 R9
            d.flash_req = 1'b1;
            d.addr = {10'h000, FLASH_BASE}; // R10
          end
          else if (q.src == SRC_I2C)
          begin
            d.st = ST_I2C; // R3 R9
            d.i2c_req = 1'b1;
            d.addr = EEPROM_RCW_BASE;
          end
          else
          begin
            d.st = ST_FIXED; // R4
          end
        end
        ST_FLASH:
        begin
          if (flash_rd_ack)
          begin
            // byte taken from the most significant lane, b0 first
            d.shreg = {q.shreg[55:0], flash_rd_data[15:8]}; // R12
            d.addr = q.addr + {10'h000, FLASH_STRIDE}; // R11
            d.idx = q.idx + 4'h1;
            if (q.idx == 4'(RCW_BYTES - 1))
            begin
              d.flash_req = 1'b0;
              d.st = ST_LATCH; // R22
            end
          end
        end
        ST_I2C:
        begin
          if (i2c_rd_err)
          begin
            d.i2c_req = 1'b0;
            d.fail = 1'b1; // R17
            d.st = ST_FAIL;
          end
          else if (i2c_rd_ack)
          begin
            d.shreg = {q.shreg[55:0], i2c_rd_data}; // R12
            d.addr = q.addr + 16'h0001; // R13
            d.idx = q.idx + 4'h1;
            if (q.idx == 4'(RCW_BYTES - 1))
            begin
              d.i2c_req = 1'b0;
              d.st = ST_LATCH;
            end
          end
        end
        ST_FIXED:
        begin
          d.shreg = FIXED_RCW_SETS[q.src - SRC_FIXED_FIRST]; // R4
          d.st = ST_LATCH;
        end
        ST_LATCH:
        begin
          d.lo = q.shreg[63:32]; // R12
          d.hi = q.shreg[31:0];
          d.latched = 1'b1; // R25
          d.hard_drive = 1'b0;
          d.st = ST_WAIT_HARD;
        end
        ST_FAIL:
        begin
          // no words: device stays in hard reset until power-on reset
          d.hard_drive = 1'b1;
        end
        ST_WAIT_HARD:
        begin
          if (hard_reset_n_in)
          begin
            if (q.hi[HI_BOOT_SEQ_BIT])
            begin
              d.st = ST_BOOT_PRE; // R16
              d.idx = 4'h0;
              d.addr = EEPROM_BOOT_BASE;
              d.i2c_req = 1'b1;
            end
            else
            begin
              d.st = ST_RUN;
            end
          end
        end
        ST_BOOT_PRE, ST_BOOT_REC:
        begin
          if (i2c_rd_err)
          begin
            d.i2c_req = 1'b0;
            d.st = ST_RUN; // R18
          end
          else if (i2c_rd_ack)
          begin
            d.rec = {q.rec[39:0], i2c_rd_data};
            d.addr = q.addr + 16'h0001;
            d.idx = q.idx + 4'h1;
            if (q.st == ST_BOOT_PRE && q.idx == 4'(BOOT_PRE_BYTES - 1))
            begin
              d.idx = 4'h0;
              if ({q.rec[15:0], i2c_rd_data} == BOOT_PREAMBLE)
              begin
                d.st = ST_BOOT_REC;
              end
              else
              begin
                d.i2c_req = 1'b0;
                d.st = ST_RUN; // R18
              end
            end
            else if (q.st == ST_BOOT_REC && q.idx == 4'(BOOT_REC_BYTES - 1))
            begin
              d.idx = 4'h0;
              if (q.rec[39:24] == BOOT_END_ADDR)
              begin
                d.i2c_req = 1'b0;
                d.st = ST_RUN;
              end
              else
              begin
                d.wr_valid = 1'b1; // R16
                d.wr_addr = q.rec[39:24];
                d.wr_data = {q.rec[23:0], i2c_rd_data};
              end
            end
          end
        end
        ST_RUN:
        begin
          if (!hard_reset_n_in)
          begin
            // an outside hard reset reloads the words
            d.st = ST_DISPATCH; // R9
            d.latched = 1'b0; // R25
            d.hard_drive = 1'b1;
            d.ctrl[RC_HARD_BIT] = 1'b0;
          end
        end
        default:
        begin
          d.st = ST_DISPATCH;
        end
      endcase
    end
    // axi4-lite write channel
    if (aw_take)
    begin
      d.aw_got = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (w_take)
    begin
      d.w_got = 1'b1;
      d.w_data = s_axi_wdata;
    end
    if ((q.aw_got || aw_take) && (q.w_got || w_take) && !q.bvalid)
    begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (wr_addr_eff == OFS_RESET_CONTROL)
      begin
        if (s_axi_wstrb[0] || q.w_got)
        begin
          d.ctrl = wr_data_eff[1:0];
        end
      end
      else if (wr_addr_eff == OFS_CONFIG_WORD_LO || wr_addr_eff == OFS_CONFIG_WORD_HI ||
               wr_addr_eff == OFS_RESET_STATUS || wr_addr_eff == OFS_PLL_MODE)
      begin
        d.bresp = RESP_OKAY; // R20
      end
      else
      begin
        d.bresp = RESP_DECERR;
      end
    end
    if (q.bvalid && s_axi_bready)
    begin
      d.bvalid = 1'b0;
    end
    // axi4-lite read channel
    if (ar_take)
    begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      if (s_axi_araddr == OFS_CONFIG_WORD_LO)
      begin
        d.rdata = q.lo; // R20
      end
      else if (s_axi_araddr == OFS_CONFIG_WORD_HI)
      begin
        d.rdata = q.hi; // R20
      end
      else if (s_axi_araddr == OFS_RESET_STATUS)
      begin
        d.rdata = status_word; // R17 R20
      end
      else if (s_axi_araddr == OFS_PLL_MODE)
      begin
        d.rdata = pll_word; // R20
      end
      else if (s_axi_araddr == OFS_RESET_CONTROL)
      begin
        d.rdata = {30'h0, q.ctrl};
      end
      else
      begin
        d.rdata = 32'h0000_0000;
        d.rresp = RESP_DECERR;
      end
    end
    else if (q.rvalid && s_axi_rready)
    begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.st <= ST_DISPATCH;
      q.hard_drive <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // bus handshakes
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready = !q.w_got && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  // open-drain reset lines: only ever pulled low
  assign hard_reset_n_out = 1'b0; // R19
  assign hard_reset_n_oe = !(q.hard_drive || q.ctrl[RC_HARD_BIT]); // R19
  assign soft_reset_n_out = 1'b0; // R19
  assign soft_reset_n_oe = !q.ctrl[RC_SOFT_BIT]; // R19

  // shared strap pins float while power-on reset is low
  assign local_bus_general_purpose_line_out = lbc_general_purpose_line; // R21
  assign local_bus_general_purpose_line_oe = {3{!power_on_reset_n}}; // R23

  // fetch ports
  assign flash_rd_req = q.flash_req;
  assign flash_rd_addr = q.addr[5:0]; // R11
  assign i2c_rd_req = q.i2c_req;
  assign i2c_dev_addr = EEPROM_DEV_ADDR; // R14
  assign i2c_mem_addr = q.addr; // R13
  assign i2c_hold_reset = (q.st == ST_WAIT_HARD); // R15
  assign cfg_wr_valid = q.wr_valid;
  assign cfg_wr_addr = q.wr_addr;
  assign cfg_wr_data = q.wr_data;

  // configuration outputs, inactive until both words are latched
  assign core_release = (q.st == ST_RUN) && soft_reset_n_in; // R15
  assign config_valid = q.latched; // R25
  assign config_word_lo = q.latched ? q.lo : 32'h0000_0000; // R25
  assign config_word_hi = q.latched ? q.hi : 32'h0000_0000; // R25
  assign system_pll_multiplier = q.latched ? q.hi[HI_MULT_LSB +: MULT_W] : '0; // R7 R8
  assign bus_clk_half = q.latched && host_mode && !q.div; // R8
  assign core_clk_double = q.latched && !host_mode && !q.div; // R7 R8

endmodule
`default_nettype wire

//--- tb/rcw_loader_monitor.sv
// concurrent checks on the configuration word loader ports
`default_nettype none
module rcw_loader_monitor
  import rcw_loader_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_on_reset_n,
  input wire logic [2:0] local_bus_general_purpose_line_oe,
  input wire logic flash_rd_req,
  input wire logic [5:0] flash_rd_addr,
  input wire logic flash_rd_ack,
  input wire logic i2c_rd_req,
  input wire logic [6:0] i2c_dev_addr,
  input wire logic i2c_hold_reset,
  input wire logic hard_reset_n_oe,
  input wire logic cfg_wr_valid,
  input wire logic config_valid,
  input wire logic [31:0] config_word_lo,
  input wire logic [31:0] config_word_hi,
  input wire logic [MULT_W-1:0] system_pll_multiplier,
  input wire logic core_release,
  input wire logic bus_clk_half,
  input wire logic core_clk_double,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  strap_pins_input_a: assert property (
    !power_on_reset_n && $past(!power_on_reset_n) |-> local_bus_general_purpose_line_oe == 3'h7)
    else $error("strap pins driven during power-on reset");
  flash_addr_step_a: assert property (
    flash_rd_req && flash_rd_ack && flash_rd_addr != 6'h38 && power_on_reset_n
    |=> flash_rd_req && flash_rd_addr == $past(flash_rd_addr) + 6'h08)
    else $error("flash address did not step by eight");
  flash_addr_hold_a: assert property (
    flash_rd_req && !flash_rd_ack |=> !flash_rd_req || $stable(flash_rd_addr))
    else $error("flash address moved before ack");
  flash_done_a: assert property (
    flash_rd_req && flash_rd_ack && flash_rd_addr == 6'h38 && power_on_reset_n
    |=> !flash_rd_req ##[1:2] config_valid)
    else $error("words not latched after eighth byte");
  outputs_gated_a: assert property (
    !config_valid |-> config_word_lo == 32'h0 && config_word_hi == 32'h0
    && system_pll_multiplier == '0 && !core_release && !hard_reset_n_oe)
    else $error("outputs active before words latched");
  eeprom_address_a: assert property (
    i2c_rd_req |-> i2c_dev_addr == EEPROM_DEV_ADDR)
    else $error("wrong eeprom calling address");
  clock_mode_a: assert property (
    config_valid |-> system_pll_multiplier == config_word_hi[27:24]
    && !(bus_clk_half && !config_word_hi[31]) && !(core_clk_double && config_word_hi[31]))
    else $error("clock mode outputs disagree with high word");
  i2c_hold_a: assert property (
    i2c_hold_reset |-> config_valid && !i2c_rd_req && !core_release)
    else $error("i2c held in reset outside the wait");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_retire_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired after handshake");
  cover property (flash_rd_ack && flash_rd_addr == 6'h38);
  cover property (cfg_wr_valid);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_DECERR);
endmodule
bind reset_config_word_loader rcw_loader_monitor u_rcw_loader_monitor (.*);
`default_nettype wire

//--- tb/rcw_partner.sv
// flash and i2c eeprom model answering the loader byte fetches
`default_nettype none
module rcw_partner
  import rcw_loader_pkg::*;
(
  input wire logic aclk,
  input wire logic slow,
  input wire logic i2c_fault,
  input wire logic flash_rd_req,
  input wire logic [5:0] flash_rd_addr,
  output logic flash_rd_ack,
  output logic [15:0] flash_rd_data,
  input wire logic i2c_rd_req,
  input wire logic [6:0] i2c_dev_addr,
  input wire logic [15:0] i2c_mem_addr,
  output logic i2c_rd_ack,
  output logic i2c_rd_err,
  output logic [7:0] i2c_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] fmem [8];
  logic [7:0] emem [24];
  logic [2:0] wait_q = 3'h0;
  initial flash_rd_data = 16'h0F0F;
  initial i2c_rd_data = 8'h3C;
  always @(posedge aclk)
  begin
    flash_rd_ack <= 1'b0;
    i2c_rd_ack <= 1'b0;
    i2c_rd_err <= 1'b0;
    flash_rd_data <= ~flash_rd_data;
    i2c_rd_data <= ~i2c_rd_data;
    if (!(flash_rd_req || i2c_rd_req) || flash_rd_ack || i2c_rd_ack || i2c_rd_err)
      wait_q <= 3'h0;
    else if (wait_q != (slow ? 3'h5 : 3'h1))
      wait_q <= wait_q + 3'h1;
    else if (flash_rd_req)
    begin
      flash_rd_ack <= 1'b1;
      flash_rd_data <= {fmem[flash_rd_addr[5:3]], 8'hA5};
    end
    else if (i2c_fault || i2c_dev_addr != EEPROM_DEV_ADDR)
      i2c_rd_err <= 1'b1;
    else
    begin
      i2c_rd_ack <= 1'b1;
      i2c_rd_data <= emem[i2c_mem_addr[4:0]];
    end
  end
endmodule
`default_nettype wire

//--- tb/reset_config_word_loader_bench.sv
// self-checking bench for the configuration word loader
`default_nettype none
module reset_config_word_loader_bench;
  import rcw_loader_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, slow;
  logic [7:0] s_axi_awaddr, s_axi_araddr, i2c_rd_data;
  logic [31:0] s_axi_wdata, s_axi_rdata, config_word_lo, config_word_hi, cfg_wr_data;
  logic [3:0] s_axi_wstrb;
  logic [MULT_W-1:0] system_pll_multiplier;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic power_on_reset_n, hard_reset_n_in, hard_reset_n_out, hard_reset_n_oe, soft_reset_n_in;
  logic soft_reset_n_out, soft_reset_n_oe, input_divide_strap, flash_rd_req, flash_rd_ack;
  logic i2c_rd_req, i2c_rd_ack, i2c_rd_err, i2c_hold_reset, cfg_wr_valid, core_release;
  logic config_valid, bus_clk_half, core_clk_double, ext_hard, i2c_fault;
  logic [2:0] local_bus_general_purpose_line_in, local_bus_general_purpose_line_out;
  logic [2:0] local_bus_general_purpose_line_oe, lbc_general_purpose_line, strap;
  logic [5:0] flash_rd_addr;
  logic [15:0] flash_rd_data, i2c_mem_addr, cfg_wr_addr;
  logic [6:0] i2c_dev_addr;
  logic [31:0] hi_x;
  int miscompares, samples_checked, cycles;
  // open-drain wires with pull-ups; board straps where the pins are released
  assign hard_reset_n_in = hard_reset_n_oe & !ext_hard;
  assign soft_reset_n_in = soft_reset_n_oe;
  assign local_bus_general_purpose_line_in = (~local_bus_general_purpose_line_oe
    & local_bus_general_purpose_line_out) | (local_bus_general_purpose_line_oe & strap);
  reset_config_word_loader u_reset_config_word_loader (.*);
  rcw_partner u_rcw_partner (.*);
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, pb;
    logic [1:0] r;
    pb = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pb)
    begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      pb = !s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      if (!pb)
        s_axi_bready <= 1'b0;
    end
    compare({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic t, pr;
    logic [31:0] d;
    logic [1:0] r;
    pr = 1'b1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (pr)
    begin
      @(negedge aclk);
      t = s_axi_arready;
      pr = !s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (t)
        s_axi_arvalid <= 1'b0;
      if (!pr)
        s_axi_rready <= 1'b0;
    end
    compare(d, ed);
    compare({30'h0, r}, {30'h0, er});
  endtask
  task automatic por(input logic [2:0] s, input logic dv);
    @(posedge aclk);
    power_on_reset_n <= 1'b0;
    strap <= s;
    input_divide_strap <= dv;
    repeat (4) @(posedge aclk);
    power_on_reset_n <= 1'b1;
  endtask
  task automatic hard_pulse;
    @(posedge aclk);
    ext_hard <= 1'b1;
    repeat (3) @(posedge aclk);
    ext_hard <= 1'b0;
  endtask
  task automatic wait_sig(input int which);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < 600 && !hit; n++)
    begin
      @(negedge aclk);
      hit = (which == 0 && config_valid === 1'b1) || (which == 1 && cfg_wr_valid === 1'b1)
        || (which == 2 && core_release === 1'b1);
    end
    if (!hit)
    begin
      miscompares++;
      print_verdict();
    end
  endtask
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  initial
  begin
    {aresetn, power_on_reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, ext_hard, i2c_fault, input_divide_strap, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    strap = 3'h0;
    slow = 1'b1;
    lbc_general_purpose_line = 3'h5;
    u_rcw_partner.fmem = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h85, 8'h00, 8'h00, 8'h00};
    u_rcw_partner.emem = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h43, 8'h00, 8'h00, 8'h00, 8'hAA,
      8'h55, 8'hAA, 8'h12, 8'h34, 8'hDE, 8'hAD, 8'hBE, 8'hEF, 8'hFF, 8'hFF, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    por(SRC_LOCAL_BUS, 1'b1);
    wait_sig(0);
    compare(config_word_lo, 32'h1234_5678);
    compare(config_word_hi, 32'h8500_0000);
    compare({bus_clk_half, core_clk_double}, 2'b00);
    compare(local_bus_general_purpose_line_out, 3'h5);
    u_rcw_partner.fmem[0] = 8'hAB;
    hard_pulse();
    wait_sig(0);
    compare(config_word_lo, 32'hAB34_5678);
    rd_chk(OFS_RESET_STATUS, 32'h70, RESP_OKAY);
    rd_chk(OFS_PLL_MODE, 32'h45, RESP_OKAY);
    wr_chk(OFS_CONFIG_WORD_LO, 32'hFFFF_FFFF, RESP_OKAY);
    rd_chk(OFS_CONFIG_WORD_LO, 32'hAB34_5678, RESP_OKAY);
    wr_chk(8'h20, 32'h1, RESP_DECERR);
    rd_chk(8'h20, 32'h0, RESP_DECERR);
    wr_chk(OFS_RESET_CONTROL, 32'h1, RESP_OKAY);
    @(negedge aclk);
    compare({soft_reset_n_oe, core_release, hard_reset_n_out, soft_reset_n_out}, 4'h0);
    wr_chk(OFS_RESET_CONTROL, 32'h0, RESP_OKAY);
    wr_chk(OFS_RESET_CONTROL, 32'h2, RESP_OKAY);
    wait_sig(2);
    rd_chk(OFS_RESET_CONTROL, 32'h0, RESP_OKAY);
    slow <= 1'b0;
    ext_hard <= 1'b1;
    por(SRC_I2C, 1'b0);
    wait_sig(0);
    compare(config_word_lo, 32'h0102_0304);
    compare({i2c_hold_reset, core_release}, 2'b10);
    compare({core_clk_double, system_pll_multiplier}, 5'h13);
    @(posedge aclk);
    ext_hard <= 1'b0;
    wait_sig(1);
    compare({cfg_wr_addr, 16'h0}, 32'h1234_0000);
    compare(cfg_wr_data, 32'hDEAD_BEEF);
    wait_sig(2);
    rd_chk(OFS_PLL_MODE, 32'h23, RESP_OKAY);
    u_rcw_partner.emem[9] = 8'h00;
    hard_pulse();
    wait_sig(2);
    rd_chk(OFS_RESET_STATUS, 32'h64, RESP_OKAY);
    i2c_fault <= 1'b1;
    hard_pulse();
    repeat (60) @(negedge aclk);
    rd_chk(OFS_RESET_STATUS, 32'h05, RESP_OKAY);
    compare({31'h0, config_valid}, 32'h0);
    i2c_fault <= 1'b0;
    for (int k = 3; k < 8; k++)
    begin
      por(3'(k), k[0]);
      wait_sig(0);
      hi_x = FIXED_RCW_SETS[k-3][31:0];
      compare(config_word_lo, FIXED_RCW_SETS[k-3][63:32]);
      compare(config_word_hi, hi_x);
      compare({flash_rd_req, i2c_rd_req}, 2'b00);
      compare({bus_clk_half, core_clk_double, system_pll_multiplier},
        {hi_x[31] & ~k[0], ~hi_x[31] & ~k[0], hi_x[27:24]});
    end
    print_verdict();
  end
endmodule
`default_nettype wire
